//--- hdl/io_unit_consts.vh
// Constants for the analog I/O unit parameter exchange block.
// Included by bare name; definitions only.
`ifndef IO_UNIT_CONSTS_VH
`define IO_UNIT_CONSTS_VH

// Word offsets inside the parameter word block
`define IO_CMD_WORD      7'h00
`define IO_G1_FIRST      7'h01
`define IO_G1_LAST       7'h27
`define IO_G2_FIRST      7'h28
`define IO_G2_LAST       7'h59
`define IO_ERR_WORD      7'h5a
`define IO_BLOCK_WORDS   7'h64

// Command word values
`define IO_CMD_DEFAULTS  16'h3039
`define IO_CMD_CLEAR     16'h0000
`define IO_NO_ERROR      16'h0000

// Range limits and default contents
`define IO_G1_MAX        16'h7fff
`define IO_G2_MAX        16'h0fff
`define IO_DEFAULT_WORD  16'h0000

// Block placement in host word space
`define IO_BASE_WORD     15'h4e20
`define IO_UNIT_STRIDE   15'h0064
`define IO_UNIT_MAX      7'h5f

// APB byte addresses
`define A_BLOCK_END      12'h190
`define A_CTRL           12'h200
`define A_STATUS         12'h204
`define A_INT_STATUS     12'h208
`define A_INT_MASK       12'h20c
`define A_BASE_WORD      12'h210
`define A_ALARM          12'h214
`define A_DISCONNECT     12'h218
`define A_CYC_IN         12'h300
`define A_CYC_OUT        12'h380
`define A_WORK           12'h400
`define A_WORK_END       12'h590

// Bit positions
`define CTRL_RESTART     0
`define INT_LAMP         0
`define INT_DEFAULTS     1
`define INT_LOADED       2
`define INT_BITS         3

// Address decode kinds
`define K_NONE           4'h0
`define K_BLOCK          4'h1
`define K_CTRL           4'h2
`define K_STATUS         4'h3
`define K_INT_STATUS     4'h4
`define K_INT_MASK       4'h5
`define K_BASE           4'h6
`define K_ALARM          4'h7
`define K_DISC           4'h8
`define K_CYC_IN         4'h9
`define K_CYC_OUT        4'ha
`define K_WORK           4'hb

`endif

//--- hdl/param_word_ram.v
// Two-port word store for the shared parameter word block.
// Port b (the unit's sequencer) wins when both ports write one word.
`timescale 1ns/1ps
module param_word_ram #(
  parameter WIDTH = 16,
  parameter DEPTH = 100,
  parameter AW    = 7
) (
  input  wire             ref_clk,
  input  wire             a_we,
  input  wire [AW-1:0]    a_addr,
  input  wire [WIDTH-1:0] a_wdata,
  output wire [WIDTH-1:0] a_rdata,
  input  wire             b_we,
  input  wire [AW-1:0]    b_addr,
  input  wire [WIDTH-1:0] b_wdata,
  output wire [WIDTH-1:0] b_rdata
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  assign a_rdata = mem[a_addr];
  assign b_rdata = mem[b_addr];

  // No reset: contents belong to the host and survive a unit restart
  always @(posedge ref_clk) begin
    if (b_we) begin
      mem[b_addr] <= b_wdata;
    end
    if (a_we && !(b_we && (b_addr == a_addr))) begin
      mem[a_addr] <= a_wdata;
    end
  end
endmodule

//--- hdl/io_unit_parameter_exchange.v
// Parameter and cyclic data exchange of an analog I/O unit, APB slave.
// Assumes front-end values arrive on ref_clk; unit number comes from switches.
// Overview of operation
// RULE1 - Command word 12345 at restart makes the unit send defaults to host.
// RULE2 - Host writes 12345 then restarts the unit to fetch defaults.
// RULE3 - After defaults are copied out the command word is cleared to zero.
// RULE4 - With command word zero every restart loads host settings into unit.
// RULE5 - Cyclic area is refreshed all the time, independent of restarts.
// RULE6 - Process and rate-of-change values go to the host in cyclic area.
// RULE7 - Alarm states and disconnection flags go to host in cyclic area.
// RULE8 - Host output values in cyclic area drive the output commands.
// RULE9 - First settings group is refreshed continuously in every host mode.
// RULE10 - Second group is copied once per restart, only if command not 12345.
// RULE11 - Any out-of-range setting in either group lights the error lamp.
// RULE12 - Offset of first out-of-range word is stored as error address.
// RULE13 - First group errors are reported during the running scan at once.
// RULE14 - Second group errors are reported only at the next restart.
// RULE15 - Host restarts the unit after changing settings or clearing errors.
// RULE16 - Block is 100 words at 20000 plus 100 times unit number 0 to 95.
// RULE17 - Error address stays zero while no range error exists.
// RULE18 - Command word is evaluated once per restart before any transfer.
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps
`include "io_unit_consts.vh"
module io_unit_parameter_exchange #(
  parameter CH = 4,
  parameter ALARM_BITS = 4
) (
  input  wire                  ref_clk,
  input  wire                  reset,
  input  wire                  psel,
  input  wire                  penable,
  input  wire                  pwrite,
  input  wire [11:0]           paddr,
  input  wire [31:0]           pwdata,
  output wire                  pready,
  output wire                  pslverr,
  output reg  [31:0]           prdata,
  input  wire [6:0]            unit_number,
  input  wire [CH*16-1:0]      process_value,
  input  wire [CH*16-1:0]      rate_value,
  input  wire [CH*ALARM_BITS-1:0] alarm_state,
  input  wire [CH-1:0]         disconnect_flag,
  output reg  [CH*16-1:0]      analog_out,
  output reg                   setting_error_lamp,
  output reg  [14:0]           block_base_word,
  output wire                  irq
);
  localparam ST_EVAL    = 3'd0;
  localparam ST_DEFAULT = 3'd1;
  localparam ST_CLEAR   = 3'd2;
  localparam ST_LOAD    = 3'd3;
  localparam ST_RUN     = 3'd4;

  reg  [2:0]             state;
  reg  [6:0]             ptr;
  reg  [15:0]            work [0:`IO_BLOCK_WORDS-1];
  reg  [15:0]            g1_err;
  reg  [15:0]            g1_pass;
  reg  [15:0]            g2_err;
  reg  [15:0]            g2_load;
  reg  [6:0]             unit_meta;
  reg  [6:0]             unit_sync;
  reg  [6:0]             unit_held;
  reg  [CH*16-1:0]       pv_cyc;
  reg  [CH*16-1:0]       rate_cyc;
  reg  [CH*ALARM_BITS-1:0] alarm_cyc;
  reg  [CH-1:0]          disc_cyc;
  reg  [`INT_BITS-1:0]   int_status;
  reg  [`INT_BITS-1:0]   int_mask;
  reg  [`INT_BITS-1:0]   int_event;
  reg                    restart_req;
  reg                    b_we;
  reg  [6:0]             b_addr;
  reg  [15:0]            b_wdata;
  reg  [31:0]            next_rdata;
  wire [15:0]            b_rdata;
  wire [15:0]            a_rdata;
  wire [15:0]            err_addr;
  wire [3:0]             kind;
  wire                   setup;
  wire                   wr_access;
  wire [11:0]            cyc_in_off;
  wire [11:0]            cyc_out_off;
  wire [11:0]            work_off;
  integer                i, j;

  function in_range;
    input [6:0]  idx;
    input [15:0] val;
    begin
      if (idx >= `IO_G1_FIRST && idx <= `IO_G1_LAST) begin
        in_range = (val <= `IO_G1_MAX);
      end else if (idx >= `IO_G2_FIRST && idx <= `IO_G2_LAST) begin
        in_range = (val <= `IO_G2_MAX);
      end else begin
        in_range = 1'b1;
      end
    end
  endfunction

  function [3:0] decode;
    input [11:0] a;
    begin
      if (a[1:0] != 2'b00) begin
        decode = `K_NONE;
      end else if (a < `A_BLOCK_END) begin
        decode = `K_BLOCK;
      end else if (a == `A_CTRL) begin
        decode = `K_CTRL;
      end else if (a == `A_STATUS) begin
        decode = `K_STATUS;
      end else if (a == `A_INT_STATUS) begin
        decode = `K_INT_STATUS;
      end else if (a == `A_INT_MASK) begin
        decode = `K_INT_MASK;
      end else if (a == `A_BASE_WORD) begin
        decode = `K_BASE;
      end else if (a == `A_ALARM) begin
        decode = `K_ALARM;
      end else if (a == `A_DISCONNECT) begin
        decode = `K_DISC;
      end else if (a >= `A_CYC_IN && a < `A_CYC_IN + CH * 8) begin
        decode = `K_CYC_IN;
      end else if (a >= `A_CYC_OUT && a < `A_CYC_OUT + CH * 4) begin
        decode = `K_CYC_OUT;
      end else if (a >= `A_WORK && a < `A_WORK_END) begin
        decode = `K_WORK;
      end else begin
        decode = `K_NONE;
      end
    end
  endfunction

  // Block start word for a unit number; out-of-range units sit at unit 0
  function [14:0] base_of;
    input [6:0] unit;
    begin
      if (unit > `IO_UNIT_MAX) begin
        base_of = `IO_BASE_WORD;
      end else begin
        base_of = `IO_BASE_WORD + `IO_UNIT_STRIDE * {8'h00, unit};
      end
    end
  endfunction

  assign kind        = decode(paddr);
  assign setup       = psel && !penable;
  assign wr_access   = psel && penable && pwrite;
  assign pready      = 1'b1;
  assign pslverr     = psel && penable && ((kind == `K_NONE) ||
                       (pwrite && (kind == `K_STATUS || kind == `K_BASE ||
                        kind == `K_ALARM || kind == `K_DISC ||
                        kind == `K_CYC_IN || kind == `K_WORK)));
  assign cyc_in_off  = paddr - `A_CYC_IN;
  assign cyc_out_off = paddr - `A_CYC_OUT;
  assign work_off    = paddr - `A_WORK;
  // First group offsets are all below second group ones, so it wins
  assign err_addr    = (g1_err != `IO_NO_ERROR) ? g1_err : g2_err; // [RULE12]
  assign irq         = |(int_status & int_mask);

  param_word_ram #(
    .WIDTH (16),
    .DEPTH (`IO_BLOCK_WORDS),
    .AW    (7)
  ) u_block (
    .ref_clk (ref_clk),
    .a_we    (wr_access && kind == `K_BLOCK && paddr[8:2] != `IO_ERR_WORD),
    .a_addr  (paddr[8:2]),
    .a_wdata (pwdata[15:0]),
    .a_rdata (a_rdata),
    .b_we    (b_we),
    .b_addr  (b_addr),
    .b_wdata (b_wdata),
    .b_rdata (b_rdata)
  );

  // Sequencer port of the block
  always @* begin
    b_we    = 1'b0;
    b_addr  = ptr;
    b_wdata = `IO_DEFAULT_WORD;
    case (state)
      ST_EVAL: begin
        b_addr = `IO_CMD_WORD;
      end
      ST_DEFAULT: begin
        b_we = 1'b1; // [RULE1]
      end
      ST_CLEAR: begin
        b_we    = 1'b1;
        b_addr  = `IO_CMD_WORD;
        b_wdata = `IO_CMD_CLEAR; // [RULE3]
      end
      default: begin
        b_we = 1'b0;
      end
    endcase
  end

  // Unit number switches are asynchronous to ref_clk
  always @(posedge ref_clk) begin
    unit_meta <= unit_number;
    unit_sync <= unit_meta;
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      state           <= ST_EVAL;
      ptr             <= `IO_G1_FIRST;
      g1_err          <= `IO_NO_ERROR;
      g1_pass         <= `IO_NO_ERROR;
      g2_err          <= `IO_NO_ERROR;
      g2_load         <= `IO_NO_ERROR;
      unit_held       <= 7'h00;
      block_base_word <= `IO_BASE_WORD;
      int_event       <= {`INT_BITS{1'b0}};
    end else begin
      int_event <= {`INT_BITS{1'b0}};
      if (restart_req) begin
        state <= ST_EVAL; // [RULE15]
      end else begin
        case (state)
          ST_EVAL: begin
            // Command word is looked at here once, before any transfer
            unit_held       <= unit_sync;
            block_base_word <= base_of(unit_sync); // [RULE16]
            ptr             <= `IO_G1_FIRST;
            g1_pass         <= `IO_NO_ERROR;
            g2_load         <= `IO_NO_ERROR;
            if (b_rdata == `IO_CMD_DEFAULTS) begin // [RULE18]
              state <= ST_DEFAULT; // [RULE1]
            end else begin
              state <= ST_LOAD; // [RULE4]
            end
          end
          ST_DEFAULT: begin
            work[ptr] <= `IO_DEFAULT_WORD;
            if (ptr == `IO_G2_LAST) begin
              state <= ST_CLEAR;
            end else begin
              ptr <= ptr + 7'd1;
            end
          end
          ST_CLEAR: begin
            // Defaults are always in range, so old errors are void
            g1_err                 <= `IO_NO_ERROR; // [RULE17]
            g2_err                 <= `IO_NO_ERROR;
            int_event[`INT_DEFAULTS] <= 1'b1;
            ptr                    <= `IO_G1_FIRST;
            state                  <= ST_RUN;
          end
          ST_LOAD: begin
            work[ptr] <= b_rdata; // [RULE10]
            if (ptr >= `IO_G2_FIRST && !in_range(ptr, b_rdata) &&
                g2_load == `IO_NO_ERROR) begin
              g2_load <= {9'h000, ptr};
            end
            if (ptr == `IO_G2_LAST) begin
              // Second group verdict is only renewed here, at restart
              if (!in_range(ptr, b_rdata) && g2_load == `IO_NO_ERROR) begin
                g2_err <= {9'h000, ptr}; // [RULE14]
              end else begin
                g2_err <= g2_load; // [RULE14]
              end
              int_event[`INT_LOADED] <= 1'b1;
              ptr                    <= `IO_G1_FIRST;
              state                  <= ST_RUN;
            end else begin
              ptr <= ptr + 7'd1;
            end
          end
          ST_RUN: begin
            // No host mode input: the scan never pauses
            work[ptr] <= b_rdata; // [RULE9]
            if (ptr == `IO_G1_LAST) begin
              if (!in_range(ptr, b_rdata) && g1_pass == `IO_NO_ERROR) begin
                g1_err <= {9'h000, ptr}; // [RULE13]
              end else begin
                g1_err <= g1_pass; // [RULE13]
              end
              g1_pass <= `IO_NO_ERROR;
              ptr     <= `IO_G1_FIRST;
            end else begin
              if (!in_range(ptr, b_rdata) && g1_pass == `IO_NO_ERROR) begin
                g1_pass <= {9'h000, ptr}; // [RULE11]
              end
              ptr <= ptr + 7'd1;
            end
          end
          default: begin
            state <= ST_EVAL;
          end
        endcase
      end
    end
  end

  // Cyclic area: sampled every cycle regardless of sequencer state
  always @(posedge ref_clk) begin
    if (reset) begin
      pv_cyc             <= {CH*16{1'b0}};
      rate_cyc           <= {CH*16{1'b0}};
      alarm_cyc          <= {CH*ALARM_BITS{1'b0}};
      disc_cyc           <= {CH{1'b0}};
      setting_error_lamp <= 1'b0;
    end else begin
      pv_cyc             <= process_value; // [RULE5] [RULE6]
      rate_cyc           <= rate_value; // [RULE6]
      alarm_cyc          <= alarm_state; // [RULE7]
      disc_cyc           <= disconnect_flag; // [RULE7]
      setting_error_lamp <= (err_addr != `IO_NO_ERROR); // [RULE11]
    end
  end

  // Register writes, restart strobe and sticky interrupt flags
  always @(posedge ref_clk) begin
    if (reset) begin
      analog_out  <= {CH*16{1'b0}};
      int_status  <= {`INT_BITS{1'b0}};
      int_mask    <= {`INT_BITS{1'b0}};
      restart_req <= 1'b0;
    end else begin
      restart_req <= wr_access && kind == `K_CTRL && pwdata[`CTRL_RESTART];
      if (wr_access && kind == `K_INT_MASK) begin
        int_mask <= pwdata[`INT_BITS-1:0];
      end
      if (wr_access && kind == `K_CYC_OUT) begin
        for (i = 0; i < CH; i = i + 1) begin
          if (cyc_out_off[11:2] == i) begin
            analog_out[i*16 +: 16] <= pwdata[15:0]; // [RULE8]
          end
        end
      end
      // Set beats a same-cycle write-one clear
      int_status <= (int_status & ~((wr_access && kind == `K_INT_STATUS) ?
                    pwdata[`INT_BITS-1:0] : {`INT_BITS{1'b0}})) |
                    int_event |
                    {{(`INT_BITS-1){1'b0}},
                     (err_addr != `IO_NO_ERROR) && !setting_error_lamp};
    end
  end

  // Read data is captured in the setup cycle, valid during access
  always @* begin
    next_rdata = 32'h0000_0000;
    case (kind)
      `K_BLOCK: begin
        if (paddr[8:2] == `IO_ERR_WORD) begin
          next_rdata = {16'h0000, err_addr}; // [RULE12]
        end else begin
          next_rdata = {16'h0000, a_rdata};
        end
      end
      `K_STATUS: begin
        next_rdata = {27'h000_0000, (unit_held > `IO_UNIT_MAX), state,
                      setting_error_lamp};
      end
      `K_INT_STATUS: begin
        next_rdata = {{(32-`INT_BITS){1'b0}}, int_status};
      end
      `K_INT_MASK: begin
        next_rdata = {{(32-`INT_BITS){1'b0}}, int_mask};
      end
      `K_BASE: begin
        next_rdata = {17'h0_0000, block_base_word};
      end
      `K_ALARM: begin
        next_rdata[CH*ALARM_BITS-1:0] = alarm_cyc;
      end
      `K_DISC: begin
        next_rdata[CH-1:0] = disc_cyc;
      end
      `K_CYC_IN: begin
        for (j = 0; j < CH; j = j + 1) begin
          if (cyc_in_off[11:3] == j) begin
            next_rdata[15:0] = cyc_in_off[2] ? rate_cyc[j*16 +: 16] :
                               pv_cyc[j*16 +: 16];
          end
        end
      end
      `K_CYC_OUT: begin
        for (j = 0; j < CH; j = j + 1) begin
          if (cyc_out_off[11:2] == j) begin
            next_rdata[15:0] = analog_out[j*16 +: 16];
          end
        end
      end
      `K_WORK: begin
        next_rdata = {16'h0000, work[work_off[8:2]]};
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= next_rdata;
    end
  end
endmodule

//--- testbench/io_unit_checker_asserts.sv
// Port checker for the parameter exchange block, bound to its top module.
// Assumes one clock domain with a synchronous active high reset.
`timescale 1ns/1ps
`include "io_unit_consts.vh"
module io_unit_checker #(
  parameter CH         = 4,
  parameter ALARM_BITS = 4
) (
  input wire logic            ref_clk,
  input wire logic            reset,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [11:0]     paddr,
  input wire logic [31:0]     pwdata,
  input wire logic            pready,
  input wire logic            pslverr,
  input wire logic [31:0]     prdata,
  input wire logic [CH*16-1:0] analog_out,
  input wire logic            setting_error_lamp,
  input wire logic [14:0]     block_base_word,
  input wire logic            irq
);
  logic [2:0] mask_seen;
  logic [3:0] since_rst;
  wire        wr_acc = psel && penable && pwrite;
  // Mirror of the mask and a count since the last restart request
  always @(posedge ref_clk) begin
    if (reset) begin
      mask_seen <= 3'h0;
      since_rst <= 4'h0;
    end else begin
      if (wr_acc && paddr == `A_INT_MASK)
        mask_seen <= pwdata[2:0];
      if (wr_acc && paddr == `A_CTRL && pwdata[0])
        since_rst <= 4'h0;
      else if (since_rst != 4'hf)
        since_rst <= since_rst + 4'h1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_rd_acc;
    psel && penable && !pwrite;
  endsequence
  sequence s_out_wr;
    psel && penable && pwrite && paddr == `A_CYC_OUT + 12'h004;
  endsequence
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_access: assert property (pslverr |-> psel && penable) else $error("pslverr early");
  a_err_misalign: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access accepted");
  a_rdata_hold: assert property (s_rd_acc |=> $stable(prdata)) else $error("prdata moved");
  a_out_write: assert property (s_out_wr |=> analog_out[31:16] == $past(pwdata[15:0]))
    else $error("output value not taken");
  a_out_cause: assert property (!$stable(analog_out) |-> $past(wr_acc))
    else $error("output changed without write");
  a_base_range: assert property (block_base_word >= 15'h4e20 && block_base_word <= 15'h733c
    && (block_base_word - 15'h4e20) % 100 == 0) else $error("base word off grid");
  a_base_restart: assert property (!$stable(block_base_word) |-> since_rst < 4'h8)
    else $error("base changed without restart");
  a_irq_masked: assert property (irq |-> mask_seen != 3'h0) else $error("irq while masked");
  a_lamp_irq: assert property ($rose(setting_error_lamp) && mask_seen[0] |-> irq)
    else $error("lamp rise without irq");
endmodule
bind io_unit_parameter_exchange io_unit_checker #(
  .CH         (CH),
  .ALARM_BITS (ALARM_BITS)
) i_chk (
  .ref_clk            (ref_clk),
  .reset              (reset),
  .psel               (psel),
  .penable            (penable),
  .pwrite             (pwrite),
  .paddr              (paddr),
  .pwdata             (pwdata),
  .pready             (pready),
  .pslverr            (pslverr),
  .prdata             (prdata),
  .analog_out         (analog_out),
  .setting_error_lamp (setting_error_lamp),
  .block_base_word    (block_base_word),
  .irq                (irq)
);

//--- testbench/host_apb.sv
// Host model: APB master standing in for the controller's CPU.
// Assumes it sits inside tb, which supplies the hang task.
`timescale 1ns/1ps
`include "io_unit_consts.vh"
module host_apb (
  input  wire logic        ref_clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic e);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    // Slave may stretch the access phase; bounded so a dead slave ends the run
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge ref_clk);
    end
    if (n == 50)
      tb.hang();
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic restart();
    logic [31:0] d;
    logic        e;
    xfer(1'b1, `A_CTRL, 32'h0000_0001, d, e);
  endtask
  task automatic fetch_defaults();
    logic [31:0] d;
    logic        e;
    xfer(1'b1, 12'h000, {16'h0, `IO_CMD_DEFAULTS}, d, e);
    restart();
  endtask
endmodule

//--- testbench/tb.sv
// Self-checking bench for the parameter exchange block.
// Assumes zero-wait APB and a block RAM that reset leaves untouched.
`timescale 1ns/1ps
`include "io_unit_consts.vh"
module tb;
  typedef struct packed {
    logic [11:0] a;
    logic        w;
    logic [31:0] d;
    logic [31:0] x;
    logic        e;
  } row_t;
  localparam row_t ROWS [13] = '{
    '{12'h300, 1'b0, 32'h0, 32'h0000_1111, 1'b0}, '{12'h318, 1'b0, 32'h0, 32'h0000_1114, 1'b0},
    '{12'h304, 1'b0, 32'h0, 32'h0000_2221, 1'b0}, '{12'h31c, 1'b0, 32'h0, 32'h0000_2224, 1'b0},
    '{`A_ALARM, 1'b0, 32'h0, 32'h0000_a5c3, 1'b0}, '{`A_DISCONNECT, 1'b0, 32'h0, 32'h9, 1'b0},
    '{12'h384, 1'b1, 32'h0000_0bee, 32'h0, 1'b0}, '{12'h384, 1'b0, 32'h0, 32'h0000_0bee, 1'b0},
    '{12'h002, 1'b0, 32'h0, 32'h0, 1'b1}, '{`A_STATUS, 1'b1, 32'h1, 32'h0, 1'b1},
    '{12'h5fc, 1'b0, 32'h0, 32'h0, 1'b1}, '{12'h168, 1'b1, 32'h0000_1234, 32'h0, 1'b0},
    '{12'h168, 1'b0, 32'h0, 32'h0, 1'b0}};
  logic [6:0]  units [3] = '{7'h5f, 7'h60, 7'h03};
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic [6:0]  unit_number = 7'h03;
  logic [63:0] process_value = 64'h1114_1113_1112_1111;
  logic [63:0] rate_value = 64'h2224_2223_2222_2221;
  logic [15:0] alarm_state = 16'ha5c3;
  logic [3:0]  disconnect_flag = 4'h9;
  logic        psel, penable, pwrite, pready, pslverr, setting_error_lamp, irq, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [63:0] analog_out;
  logic [14:0] block_base_word;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          w;
  always #5 ref_clk = ~ref_clk;
  io_unit_parameter_exchange #(.CH(4), .ALARM_BITS(4)) i_dut (
    .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .unit_number(unit_number), .process_value(process_value), .rate_value(rate_value),
    .alarm_state(alarm_state), .disconnect_flag(disconnect_flag), .analog_out(analog_out),
    .setting_error_lamp(setting_error_lamp), .block_base_word(block_base_word), .irq(irq));
  host_apb i_host (
    .ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata));
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic hang();
    error_cnt++;
    $display("[FAIL] wait bound used up");
    stop_test();
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    i_host.xfer(1'b0, a, 32'h0, q, e);
    chk($sformatf("word at %h", a), q, exp);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, q, e);
  endtask
  task automatic wait_run();
    int n;
    n = 0;
    // Poll the state field until the sequencer reports run
    do begin
      i_host.xfer(1'b0, `A_STATUS, 32'h0, q, e);
      n++;
    end while (q[3:1] !== 3'h4 && n < 200);
    if (n == 200)
      hang();
  endtask
  task automatic do_reset();
    reset <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk("prdata", prdata, 32'h0);
    chk("analog out", {31'h0, |analog_out}, 32'h0);
    chk("lamp irq", {30'h0, setting_error_lamp, irq}, 32'h0);
    chk("base", {17'h0, block_base_word}, 32'h0000_4e20);
    @(posedge ref_clk);
    reset <= 1'b0;
  endtask
  initial begin
    do_reset();
    $display("test reset done");
    // RAM is not cleared by reset, so load known contents first
    for (w = 1; w < 90; w++)
      wr(12'(4 * w), 32'h0);
    wr(12'h000, 32'h0);
    wr(`A_INT_STATUS, 32'h0000_0007);
    i_host.restart();
    wait_run();
    rd(`A_INT_STATUS, 32'h0000_0004);
    foreach (ROWS[i]) begin
      i_host.xfer(ROWS[i].w, ROWS[i].a, ROWS[i].d, q, e);
      if (!ROWS[i].w)
        chk($sformatf("row %0d", i), q, ROWS[i].x);
      chk($sformatf("row %0d error", i), {31'h0, e}, {31'h0, ROWS[i].e});
    end
    #1;
    chk("analog ch1", {16'h0, analog_out[31:16]}, 32'h0000_0bee);
    @(posedge ref_clk);
    process_value <= 64'h1114_1113_1112_5a5a;
    repeat (3) @(posedge ref_clk);
    rd(12'h300, 32'h0000_5a5a);
    $display("test cyclic done");
    foreach (units[i]) begin
      @(posedge ref_clk);
      unit_number <= units[i];
      repeat (3) @(posedge ref_clk);
      i_host.restart();
      wait_run();
      #1;
      chk("base", {17'h0, block_base_word}, (units[i] > 7'h5f) ? 32'h0000_4e20 :
          32'h0000_4e20 + 32'h0000_0064 * units[i]);
      rd(`A_STATUS, {27'h0, units[i] > 7'h5f, 3'h4, 1'b0});
    end
    $display("test unit done");
    wr(`A_INT_MASK, 32'h0);
    #1;
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(`A_INT_MASK, 32'h0000_0004);
    #1;
    chk("irq loaded", {31'h0, irq}, 32'h1);
    wr(`A_INT_STATUS, 32'h0000_0004);
    #1;
    chk("irq cleared", {31'h0, irq}, 32'h0);
    wr(`A_INT_MASK, 32'h0000_0001);
    // Word 5 sits exactly on the limit and must not be reported
    wr(12'h014, 32'h0000_7fff);
    wr(12'h028, 32'h0000_8000);
    wr(12'h050, 32'h0000_8000);
    repeat (100) @(posedge ref_clk);
    rd(12'h168, 32'h0000_000a);
    rd(12'h414, 32'h0000_7fff);
    #1;
    chk("lamp irq", {30'h0, setting_error_lamp, irq}, 32'h3);
    wr(12'h028, 32'h0);
    wr(12'h050, 32'h0);
    repeat (100) @(posedge ref_clk);
    rd(12'h168, 32'h0);
    wr(`A_INT_STATUS, 32'h0000_0001);
    #1;
    chk("lamp irq", {30'h0, setting_error_lamp, irq}, 32'h0);
    $display("test group one done");
    wr(12'h0b4, 32'h0000_0fff);
    wr(12'h0f0, 32'h0000_1000);
    repeat (100) @(posedge ref_clk);
    rd(12'h168, 32'h0);
    rd(12'h4b4, 32'h0);
    i_host.restart();
    wait_run();
    rd(12'h168, 32'h0000_003c);
    rd(12'h4b4, 32'h0000_0fff);
    #1;
    chk("lamp", {31'h0, setting_error_lamp}, 32'h1);
    $display("test group two done");
    wr(`A_INT_STATUS, 32'h0000_0007);
    i_host.fetch_defaults();
    wait_run();
    rd(12'h000, 32'h0);
    rd(12'h0f0, 32'h0);
    rd(12'h014, 32'h0);
    rd(12'h168, 32'h0);
    rd(`A_INT_STATUS, 32'h0000_0002);
    wr(12'h0b4, 32'h0000_0077);
    i_host.restart();
    wait_run();
    rd(12'h4b4, 32'h0000_0077);
    rd(12'h000, 32'h0);
    $display("test defaults done");
    do_reset();
    $display("test second reset done");
    stop_test();
  end
endmodule
